/* core/conv_ctrl.sv */
// Function
// - Trigger code picks analog input 0..11 (12..15 give 11) or external input 0..3.
// - Without external trigger inputs, the source select bit is ignored.
// - Writes to control 0..4, compare enable or direction abort the sequence.
// - Results are unsigned; justify bit chooses left (0) or right (1).
// - Four-bit sequence length, resetting to four.
// - Without FIFO mode, n-th result goes to n-th result register.
// - In FIFO mode the counter persists across sequences and wraps.
// - Abort or sequence start clears the counter, even in FIFO mode.
// - FIFO mode disables automatic compare and its interrupt.
// - Two-bit freeze field selects response to a debug freeze request.
// - Status writes leave the counter alone; counter shows next slot.
// - Sequence done flag sets per sequence; clears by one, start, fast read.
// - Edge trigger during a sequence sets trigger overrun; clears by one, abort, start.
// - Storing over a set conversion done flag sets result overrun.
// - Right justified 8/10-bit data zero the bits above.
// - Compare always uses all twelve bits of the new sample and the slot's previous sample.
//
// The address-and-strobe port was decided locally.
`include "conv_ctrl_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int SLOTS = 12,
    parameter bit HAS_EXT_TRIG = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [11:0] analog_input,
    input wire logic [3:0] external_trigger_input,
    input wire logic debug_freeze,
    input wire logic conv_valid,
    input wire logic [11:0] conv_data,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic [1:0] conv_resolution,
    output logic compare_hit,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] ctl3;
        logic [7:0] ctl4;
        logic [7:0] ctl5;
        logic [2:0] stat_flags;
        logic [2:0] irq_mask;
        logic [3:0] result_slot_counter;
        logic [3:0] done_count;
        logic [SLOTS-1:0] conversion_done_flag;
        logic [SLOTS-1:0] channel_compare_enable;
        logic [SLOTS-1:0] compare_direction;
        logic [SLOTS-1:0][15:0] result;
        logic [SLOTS-1:0][11:0] raw;
        seq_state_t state;
        logic [7:0] timer;
        logic [3:0] chan;
        logic [15:0] pin_meta;
        logic [15:0] pin_sync;
        logic trig_prev;
        logic [15:0] rdata;
        logic conv_start;
        logic compare_hit;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [15:0] fmt_word;
    logic [3:0] trig_code;
    logic trig_sel;
    logic trig_src;
    logic trig_edge;
    logic cmp_active;
    logic [3:0] seq_len;
    logic [3:0] slot;
    logic is_abort;
    logic is_start;
    logic fast_clear;
    logic cmp_hi;
    logic [SLOTS-1:0] set_ccf;
    logic seq_end;

    function automatic logic [3:0] wrap_inc(input logic [3:0] v);
        if (v == 4'(SLOTS - 1))
            wrap_inc = 4'h0;
        else
            wrap_inc = v + 4'h1;
    endfunction

    result_formatter u_fmt (
        .raw(conv_data),
        .resolution(s_r.ctl1[6:5]),
        .justify_right(s_r.ctl3[`CTL3_DJM]),
        .word(fmt_word)
    );

    // ****************************************************************
    // Trigger source selection
    // ****************************************************************
    always_comb
    begin
        trig_code = s_r.ctl1[3:0];
        trig_sel = s_r.ctl1[`CTL1_TRIG_SEL] & HAS_EXT_TRIG;
        trig_src = 1'b0;
        if (trig_sel)
        begin
            if (trig_code[3:2] == 2'b00)
                trig_src = s_r.pin_sync[{2'b11, trig_code[1:0]}];
            else
                trig_src = 1'b0;
        end
        else if (trig_code > 4'hB)
            trig_src = s_r.pin_sync[11];
        else
            trig_src = s_r.pin_sync[trig_code];
    end

    // ****************************************************************
    // Sequence control and register file
    // ****************************************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.conv_start = 1'b0;
        s_nxt.compare_hit = 1'b0;
        s_nxt.rdata = 16'h0000;
        s_nxt.pin_meta = {external_trigger_input, analog_input};
        s_nxt.pin_sync = s_r.pin_meta;
        trig_edge = trig_src & ~s_r.trig_prev;
        s_nxt.trig_prev = trig_src;
        set_ccf = '0;
        seq_end = 1'b0;
        seq_len = (s_r.ctl3[6:3] == 4'h0 || s_r.ctl3[6:3] > 4'(SLOTS))
            ? 4'(SLOTS) : s_r.ctl3[6:3];
        cmp_active = ~s_r.ctl3[`CTL3_FIFO];
        fast_clear = s_r.ctl2[6];
        slot = s_r.result_slot_counter;
        is_abort = wr && (addr <= `OFS_CTL4 || addr == `OFS_CMPE
            || addr == `OFS_CMPHT);
        is_start = wr && addr == `OFS_CTL5;
        cmp_hi = 1'b0;
        // Freeze handling
        if (s_r.state == ST_CONV && debug_freeze && s_r.ctl3[1:0] == 2'b11)
            s_nxt.state = ST_FROZEN;
        else if (s_r.state == ST_FROZEN && !debug_freeze)
            s_nxt.state = ST_CONV;
        // Running conversion
        if (s_r.state == ST_CONV && s_r.timer != 8'h00)
            s_nxt.timer = s_r.timer - 8'h01;
        if (s_r.state == ST_CONV && conv_valid)
        begin
            if (s_r.conversion_done_flag[slot])
                s_nxt.stat_flags[0] = 1'b1;
            s_nxt.raw[slot] = conv_data;
            s_nxt.result[slot] = fmt_word;
            s_nxt.conversion_done_flag[slot] = 1'b1;
            set_ccf[slot] = 1'b1;
            cmp_hi = conv_data > s_r.raw[slot];
            if (cmp_active && s_r.channel_compare_enable[slot])
                s_nxt.compare_hit = (cmp_hi == s_r.compare_direction[slot]);
            s_nxt.chan = s_r.chan + 4'h1;
            if (s_r.ctl3[`CTL3_FIFO])
                s_nxt.result_slot_counter = wrap_inc(slot);
            else
                s_nxt.result_slot_counter = wrap_inc(slot);
            if (s_r.done_count + 4'h1 == seq_len)
            begin
                s_nxt.stat_flags[2] = 1'b1;
                seq_end = 1'b1;
                s_nxt.done_count = 4'h0;
                if (!s_r.ctl3[`CTL3_FIFO])
                    s_nxt.result_slot_counter = 4'h0;
                if (s_r.ctl5[`CTL5_SCAN])
                    s_nxt.conv_start = 1'b1;
                else
                    s_nxt.state = ST_IDLE;
            end
            else
            begin
                s_nxt.done_count = s_r.done_count + 4'h1;
                s_nxt.conv_start = 1'b1;
            end
        end
        // External trigger
        if (s_r.ctl2[`CTL2_TRIG_EN] && trig_edge)
        begin
            if (s_r.state != ST_IDLE && !s_r.ctl2[`CTL2_TRIG_LEVEL])
                s_nxt.stat_flags[1] = 1'b1;
            else if (s_r.state == ST_IDLE)
            begin
                s_nxt.state = ST_CONV;
                s_nxt.conv_start = 1'b1;
                s_nxt.timer = `CONV_CYCLES;
            end
        end
        // Register reads
        if (rd)
        begin
            case (addr)
                `OFS_CTL0: s_nxt.rdata = {8'h00, s_r.ctl0};
                `OFS_CTL1: s_nxt.rdata = {8'h00, s_r.ctl1};
                `OFS_CTL2: s_nxt.rdata = {8'h00, s_r.ctl2};
                `OFS_CTL3: s_nxt.rdata = {8'h00, s_r.ctl3};
                `OFS_CTL4: s_nxt.rdata = {8'h00, s_r.ctl4};
                `OFS_CTL5: s_nxt.rdata = {8'h00, s_r.ctl5};
                `OFS_STAT0: s_nxt.rdata = {8'h00, s_r.stat_flags[2], 1'b0,
                    s_r.stat_flags[1:0], s_r.result_slot_counter};
                `OFS_IRQ_MASK: s_nxt.rdata = {13'h0000, s_r.irq_mask};
                `OFS_CMPE: s_nxt.rdata = 16'(s_r.channel_compare_enable);
                `OFS_CMPHT: s_nxt.rdata = 16'(s_r.compare_direction);
                `OFS_CCF: s_nxt.rdata = 16'(s_r.conversion_done_flag);
                default:
                begin
                    if (addr >= `OFS_RESULT0 && addr < `OFS_RESULT0 + 8'(SLOTS))
                    begin
                        s_nxt.rdata = s_r.result[addr[3:0]];
                        if (fast_clear)
                        begin
                            s_nxt.stat_flags[2] = seq_end;
                            s_nxt.conversion_done_flag[addr[3:0]] = set_ccf[addr[3:0]];
                        end
                    end
                end
            endcase
        end
        // Register writes
        if (wr)
        begin
            case (addr)
                `OFS_CTL0: s_nxt.ctl0 = wdata[7:0];
                `OFS_CTL1: s_nxt.ctl1 = wdata[7:0];
                `OFS_CTL2: s_nxt.ctl2 = wdata[7:0];
                `OFS_CTL3: s_nxt.ctl3 = wdata[7:0];
                `OFS_CTL4: s_nxt.ctl4 = wdata[7:0];
                `OFS_CTL5: s_nxt.ctl5 = wdata[7:0];
                `OFS_STAT0:
                begin
                    // Set wins over clear unless the flag was already set; counter is never written
                    s_nxt.stat_flags = s_nxt.stat_flags & ~({wdata[7], wdata[5:4]}
                        & ~(s_nxt.stat_flags & ~s_r.stat_flags));
                end
                `OFS_IRQ_MASK: s_nxt.irq_mask = wdata[2:0];
                `OFS_CMPE: s_nxt.channel_compare_enable = wdata[SLOTS-1:0];
                `OFS_CMPHT: s_nxt.compare_direction = wdata[SLOTS-1:0];
                `OFS_CCF: s_nxt.conversion_done_flag = (s_nxt.conversion_done_flag
                    & ~wdata[SLOTS-1:0]) | set_ccf;
                default:
                begin
                end
            endcase
        end
        if (is_abort || is_start)
        begin
            s_nxt.result_slot_counter = 4'h0;
            s_nxt.done_count = 4'h0;
            s_nxt.stat_flags[1:0] = 2'b00;
            s_nxt.state = ST_IDLE;
            s_nxt.conv_start = 1'b0;
        end
        if (is_start)
        begin
            s_nxt.stat_flags[2] = 1'b0;
            s_nxt.chan = wdata[3:0];
            s_nxt.state = ST_CONV;
            s_nxt.conv_start = 1'b1;
            s_nxt.timer = `CONV_CYCLES;
        end
        s_nxt.irq = |(s_nxt.stat_flags & s_nxt.irq_mask)
            | (s_nxt.compare_hit & s_r.ctl2[`CTL2_CMP_IE] & cmp_active);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.ctl1 <= `CTL1_RESET;
            s_r.ctl2 <= `CTL2_RESET;
            s_r.ctl3 <= `CTL3_RESET;
            s_r.ctl4 <= `CTL4_RESET;
            s_r.state <= ST_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    assign rdata = s_r.rdata;
    assign conv_start = s_r.conv_start;
    assign conv_channel = s_r.chan;
    assign conv_resolution = s_r.ctl1[6:5];
    assign compare_hit = s_r.compare_hit;
    assign irq = s_r.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_store;
        s_r.state == ST_CONV && conv_valid && !wr;
    endsequence

    chk_abort_clears: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `OFS_CTL2 |=> s_r.state == ST_IDLE && s_r.result_slot_counter == 4'h0)
        else $error("abort did not stop sequence");
    chk_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
        is_start |=> s_r.result_slot_counter == 4'h0 && !s_r.stat_flags[2])
        else $error("start did not clear counter");
    chk_slot_steps: assert property (@(posedge clk) disable iff (!rst_n)
        s_store ##0 s_r.ctl3[`CTL3_FIFO] |=>
        s_r.conversion_done_flag[$past(slot)] &&
        s_r.result_slot_counter == wrap_inc($past(slot)))
        else $error("counter did not advance");
    chk_res_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        s_store ##0 s_r.conversion_done_flag[slot] |=> s_r.stat_flags[0])
        else $error("result overrun missed");
    chk_trig_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == ST_CONV && trig_edge && s_r.ctl2[`CTL2_TRIG_EN] &&
        !s_r.ctl2[`CTL2_TRIG_LEVEL] && !wr |=> s_r.stat_flags[1])
        else $error("trigger overrun missed");
    chk_fifo_no_cmp: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.ctl3[`CTL3_FIFO] && !wr |=> !s_r.compare_hit)
        else $error("compare active in fifo mode");
    chk_stat_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `OFS_STAT0 && !(s_r.state == ST_CONV && conv_valid) |=>
        s_r.result_slot_counter == $past(s_r.result_slot_counter))
        else $error("status write changed counter");
    chk_seq_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> s_r.ctl3[6:3] == 4'h4)
        else $error("bad reset sequence length");
    chk_freeze_pause: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == ST_CONV && debug_freeze && s_r.ctl3[1:0] == 2'b11 && !wr
        && !conv_valid |=> s_r.state == ST_FROZEN)
        else $error("freeze did not pause");
endmodule
`default_nettype wire

/* core/conv_ctrl_pkg.sv */
package conv_ctrl_pkg;
    typedef enum logic [1:0] {
        RES_8 = 2'b00,
        RES_10 = 2'b01,
        RES_12 = 2'b10
    } resolution_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_FROZEN = 3'b100
    } seq_state_t;
endpackage

/* core/conv_ctrl_regs.svh */
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CTL0 8'h00
`define OFS_CTL1 8'h01
`define OFS_CTL2 8'h02
`define OFS_CTL3 8'h03
`define OFS_CTL4 8'h04
`define OFS_CTL5 8'h05
`define OFS_STAT0 8'h06
`define OFS_IRQ_MASK 8'h07
`define OFS_CMPE 8'h08
`define OFS_CMPHT 8'h0A
`define OFS_CCF 8'h0C
`define OFS_RESULT0 8'h10
// ****************************************************************
// Field positions
// ****************************************************************
`define CTL1_TRIG_SEL 4
`define CTL2_TRIG_LEVEL 2
`define CTL2_TRIG_EN 1
`define CTL2_CMP_IE 0
`define CTL3_DJM 7
`define CTL3_FIFO 2
`define CTL5_SCAN 5
`define STAT_SEQ_DONE 7
`define STAT_TRIG_OVR 5
`define STAT_RES_OVR 4
// ****************************************************************
// Reset values
// ****************************************************************
`define CTL1_RESET 8'h0F
`define CTL2_RESET 8'h00
`define CTL3_RESET 8'h20
`define CTL4_RESET 8'h00
// ****************************************************************
// Timing counts
// ****************************************************************
`define CONV_CYCLES 8'h10
`endif

/* core/result_formatter.sv */
`timescale 1ns/1ns
`default_nettype none
module result_formatter
    import conv_ctrl_pkg::*;
(
    input wire logic [11:0] raw,
    input wire logic [1:0] resolution,
    input wire logic justify_right,
    output logic [15:0] word
);
    // ****************************************************************
    // Justification of unsigned result data
    // ****************************************************************
    always_comb
    begin
        word = 16'h0000;
        case (resolution)
            RES_8:
            begin
                if (justify_right)
                    word = {8'h00, raw[11:4]};
                else
                    word = {raw[11:4], 8'h00};
            end
            RES_10:
            begin
                if (justify_right)
                    word = {6'h00, raw[11:2]};
                else
                    word = {raw[11:2], 6'h00};
            end
            default:
            begin
                if (justify_right)
                    word = {4'h0, raw};
                else
                    word = {raw, 4'h0};
            end
        endcase
    end
endmodule
`default_nettype wire

/* test/adc_sequence_result_control_tb.sv */
`include "conv_ctrl_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_result_control_tb
    import conv_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, wr, rd, conv_valid, conv_start, irq, compare_hit, hit_seen, debug_halt_response;
    logic [1:0] conv_res, res_sel;
    logic [7:0] addr, delay;
    logic [15:0] wdata, rdata, v;
    logic [11:0] ain, next_data, conv_data, prv;
    logic [3:0] external_trigger_enable, conv_chan;
    logic [31:0] rs = 32'h00000013;
    logic [11:0] q[$];
    int miscompares, n_compared, nval;

    always #20 clk = ~clk;

    conv_ctrl conv_ctrl_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .analog_input(ain), .external_trigger_input(external_trigger_enable),
        .debug_freeze(debug_halt_response), .conv_valid(conv_valid), .conv_data(conv_data),
        .conv_start(conv_start), .conv_channel(conv_chan), .conv_resolution(conv_res),
        .compare_hit(compare_hit), .irq(irq));

    conv_frontend_model conv_frontend_model_i (.clk(clk), .rst_n(rst_n),
        .conv_start(conv_start), .delay(delay), .next_data(next_data),
        .conv_valid(conv_valid), .conv_data(conv_data));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction

    // Result word from the top bits of the 12-bit sample, by resolution and justification
    function automatic logic [15:0] exp_word(input logic [11:0] r, input logic [1:0] m,
        input logic dj);
        logic [15:0] w;
        w = {r, 4'h0};
        if (m == 2'b00)
            w[7:0] = 8'h00;
        else if (m == 2'b01)
            w[5:0] = 6'h00;
        if (dj)
            w = w >> ((m == 2'b00) ? 8 : (m == 2'b01) ? 6 : 4);
        return w;
    endfunction

    // ****************************************************************
    // Reference model
    // ****************************************************************
    always @(posedge clk)
    begin
        rs <= xorshift(rs);
        next_data <= rs[11:0];
        if (conv_valid === 1'b1)
        begin
            q.push_back(conv_data);
            nval <= nval + 1;
        end
        if (compare_hit === 1'b1)
            hit_seen <= 1'b1;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 500; i++)
        begin
            rd_reg(`OFS_STAT0, v);
            if (v[`STAT_SEQ_DONE] === 1'b1)
                return;
        end
        miscompares++;
        finish_test();
    endtask

    task automatic run_seq(input logic [15:0] c3, input int n);
        int i;
        logic [15:0] e;
        wr_reg(`OFS_CTL3, c3);
        q.delete();
        wr_reg(`OFS_CTL5, 16'h0000);
        wait_done();
        check(16'(q.size()), 16'(n));
        check({12'h0, conv_chan}, 16'(n));
        check({14'h0, conv_res}, {14'h0, res_sel});
        for (i = 0; i < n; i++)
        begin
            rd_reg(8'(`OFS_RESULT0 + i), v);
            e = exp_word(q[i], res_sel, c3[`CTL3_DJM]);
            check(v, e);
        end
    endtask

    task automatic trig_case(input logic [15:0] c1, input logic [15:0] pins, input logic exp);
        int i;
        wr_reg(`OFS_CTL1, c1);
        wr_reg(`OFS_CTL2, 16'h0002);
        wr_reg(`OFS_CTL5, 16'h0000);
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk);
            {external_trigger_enable, ain} <= pins;
            repeat (3) @(posedge clk);
            {external_trigger_enable, ain} <= 16'h0000;
            repeat (3) @(posedge clk);
        end
        rd_reg(`OFS_STAT0, v);
        check({15'h0, v[`STAT_TRIG_OVR]}, {15'h0, exp});
        wr_reg(`OFS_CTL2, 16'h0002);
        rd_reg(`OFS_STAT0, v);
        check({15'h0, v[`STAT_TRIG_OVR]}, 16'h0000);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        int i;
        int base;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        ain = 12'h000;
        external_trigger_enable = 4'h0;
        delay = 8'h03;
        hit_seen = 1'b0;
        debug_halt_response = 1'b0;
        res_sel = 2'b10;
        miscompares = 0;
        n_compared = 0;
        nval = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`OFS_CTL3, v);
        check(v, 16'h0020);
        rd_reg(`OFS_CTL1, v);
        check(v, 16'h000F);
        wr_reg(`OFS_IRQ_MASK, 16'h0006);
        wr_reg(`OFS_CTL1, 16'h004F);
        run_seq(16'h00A0, 4);
        check({15'h0, irq}, 16'h0001);
        rd_reg(`OFS_STAT0, v);
        check(v, 16'h0080);
        rd_reg(`OFS_CCF, v);
        check(v, 16'h000F);
        wr_reg(`OFS_STAT0, 16'h0080);
        rd_reg(`OFS_STAT0, v);
        check(v, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        run_seq(16'h0020, 4);
        rd_reg(`OFS_STAT0, v);
        check(v, 16'h0090);
        wr_reg(`OFS_IRQ_MASK, 16'h0000);
        rd_reg(`OFS_STAT0, v);
        check({15'h0, irq}, 16'h0000);
        wr_reg(`OFS_STAT0, 16'h00FF);
        wr_reg(`OFS_CCF, 16'h0FFF);
        wr_reg(`OFS_CMPE, 16'h0FFF);
        wr_reg(`OFS_CTL2, 16'h0001);
        run_seq(16'h009C, 3);
        rd_reg(`OFS_STAT0, v);
        check(v, 16'h0083);
        wr_reg(`OFS_STAT0, 16'h008F);
        rd_reg(`OFS_STAT0, v);
        check(v, 16'h0003);
        run_seq(16'h009C, 3);
        delay <= 8'h28;
        base = nval;
        wr_reg(`OFS_CTL5, 16'h0020);
        for (i = 0; i < 3000 && nval < base + 5; i++)
            @(posedge clk);
        if (i == 3000)
        begin
            miscompares++;
            finish_test();
        end
        check(16'(nval - base), 16'h0005);
        rd_reg(`OFS_STAT0, v);
        check({12'h0, v[3:0]}, 16'h0005);
        check({15'h0, hit_seen}, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        wr_reg(`OFS_CTL2, 16'h0000);
        rd_reg(`OFS_STAT0, v);
        check({12'h0, v[3:0]}, 16'h0000);
        wr_reg(`OFS_CMPE, 16'h0001);
        wr_reg(`OFS_CTL1, 16'h000F);
        res_sel = 2'b00;
        @(posedge clk);
        debug_halt_response <= 1'b1;
        run_seq(16'h0088, 1);
        prv = q[0];
        hit_seen <= 1'b0;
        wr_reg(`OFS_CTL1, 16'h002F);
        res_sel = 2'b01;
        run_seq(16'h0008, 1);
        check({15'h0, hit_seen}, 16'(q[0] <= prv));
        wr_reg(`OFS_CCF, 16'h0FFF);
        wr_reg(`OFS_CTL3, 16'h008B);
        wr_reg(`OFS_CTL5, 16'h0000);
        repeat (60) @(posedge clk);
        debug_halt_response <= 1'b0;
        rd_reg(`OFS_CCF, v);
        check(v, 16'h0000);
        wr_reg(`OFS_CTL3, 16'h0090);
        trig_case(16'h004E, 16'h0800, 1'b1);
        trig_case(16'h004E, 16'h0400, 1'b0);
        trig_case(16'h0052, 16'h4000, 1'b1);
        trig_case(16'h005A, 16'h4000, 1'b0);
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire

/* test/conv_frontend_model.sv */
`timescale 1ns/1ns
`default_nettype none
module conv_frontend_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic [7:0] delay,
    input wire logic [11:0] next_data,
    output logic conv_valid,
    output logic [11:0] conv_data
);
    int cnt;
    logic [11:0] held;

    // Answers each start delay+1 cycles after it; idle data is never the last value
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            conv_valid <= 1'b0;
            conv_data <= 12'h000;
            held <= 12'h000;
        end
        else
        begin
            conv_valid <= 1'b0;
            conv_data <= ~held;
            if (conv_start)
                cnt <= int'(delay) + 1;
            else if (cnt == 1)
            begin
                conv_valid <= 1'b1;
                conv_data <= next_data;
                held <= next_data;
                cnt <= 0;
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire
